// file: design/keyboard_io_unit.sv
/*
  Keyboard unit on the eight-bit parallel I/O bus: device select, status
  and character reads, control word lamps, tone and click, front panel
  run, stop and restart keys.
  Assumes all inputs synchronous to sys_clk_in; bus commands are pulses
  several cycles long, acted on at their rising edge; the key encoder
  holds its code while key_valid_in is high and key_ready_out is low.
*/
// Functional notes
// - Responds only after a select command carrying its own address word.
// - Shared address: reads come from keyboard, writes go to display.
// - Status word presented on input lines after selection.
// - Status bit 1 high while a typed character waits.
// - Status bits 2 and 3 show keyboard and display switches.
// - Momentary switch press sets its flag; readable any time.
// - Tone command gives 1500 Hz tone for about 100 ms.
// - Click command gives one audible click.
// - Control word bit 5 drives keyboard lamp, bit 6 display lamp.
// - Main keys deliver seven-bit ASCII codes, enter, cancel, backspace, delete.
// - Pad gives digit and period codes, or control codes by option.
// - Run key starts processor at its program counter.
// - Stop key halts only after current instruction completes.
// - Stop key aborts any tape operation in progress.
// - With auto-restart tab removed, stop performs full restart.
// - Restart key halts, rewinds deck 1, loads and runs first record.
// - Address word is device number low, its complement high.
// - Status on input lines when addressed, data after sense-data command.
`timescale 1ns/10ps
`default_nettype none
`include "keyboard_io_unit_params.svh"

module keyboard_io_unit
  import keyboard_io_unit_pkg::*;
#(
  parameter int TONE_CYCLES = `KB_TONE_CYCLES,
  parameter int CLICK_CYCLES = `KB_CLICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] bus_wdata_in,
  output logic [7:0] bus_rdata_out,
  output logic bus_rdata_oe_out,
  input wire logic select_device_command_in,
  input wire logic sense_status_command_in,
  input wire logic sense_data_command_in,
  input wire logic control_word_command_in,
  input wire logic tone_command_in,
  input wire logic click_command_in,
  input wire logic input_strobe_in,
  input wire logic display_ready_in,
  input wire logic key_valid_in,
  input wire logic key_is_pad_in,
  input wire logic [6:0] key_code_in,
  input wire logic [3:0] pad_index_in,
  input wire logic pad_control_option_in,
  output logic key_ready_out,
  input wire logic keyboard_switch_in,
  input wire logic display_switch_in,
  output logic keyboard_lamp_out,
  output logic display_lamp_out,
  output logic tone_out,
  output logic click_out,
  input wire logic run_key_in,
  input wire logic stop_key_in,
  input wire logic restart_key_in,
  input wire logic auto_restart_tab_removed_in,
  input wire logic instr_done_in,
  output logic run_request_out,
  output logic halt_request_out,
  output logic restart_load_out,
  output logic tape_abort_out
);

  // Command line indices in the edge detector
  localparam int CMD_SEL = 0;
  localparam int CMD_STAT = 1;
  localparam int CMD_DATA = 2;
  localparam int CMD_CW = 3;
  localparam int CMD_TONE = 4;
  localparam int CMD_CLICK = 5;
  localparam int CMD_SPARE = 6;

  // Counter limits at counter width
  localparam logic [19:0] TONE_LEN = TONE_CYCLES[19:0];
  localparam int TONE_HALF_INT = `KB_TONE_HALF_CYCLES;
  localparam logic [11:0] TONE_HALF = TONE_HALF_INT[11:0];
  localparam logic [15:0] CLICK_LEN = CLICK_CYCLES[15:0];

  kb_state_s q;
  kb_state_s d;

  logic [6:0] cmd_now;
  logic [6:0] cmd_edge;
  logic strobe_edge;
  logic [2:0] key_now;
  logic [2:0] key_edge;
  logic push;
  logic pop;
  logic [6:0] push_code;
  logic [7:0] status_word;

  // Address word check: number in low nibble, complement in high nibble
  function automatic logic addr_match(input logic [7:0] word, input logic [3:0] num);
    addr_match = (word[3:0] == num) && (word[7:4] == ~num);
  endfunction

  // Pad key to code: digits and period, or control codes by option
  function automatic logic [6:0] pad_code(input logic [3:0] idx, input logic ctl);
    logic [6:0] base;
    base = ctl ? `KB_PAD_CTL_BASE : `KB_PAD_DIGIT_BASE;
    if (idx == `KB_PAD_PERIOD_IDX) begin
      pad_code = ctl ? `KB_PAD_CTL_PERIOD_CODE : `KB_PAD_PERIOD_CODE;
    end else begin
      pad_code = base + {3'h0, idx};
    end
  endfunction

  // Edge detection of commands, strobe and panel keys
  assign cmd_now = {1'b0, click_command_in, tone_command_in, control_word_command_in,
                    sense_data_command_in, sense_status_command_in, select_device_command_in};
  assign cmd_edge = cmd_now & ~q.cmd_prev;
  assign strobe_edge = input_strobe_in & ~q.strobe_prev;
  assign key_now = {restart_key_in, stop_key_in, run_key_in};
  assign key_edge = key_now & ~q.key_prev;

  // Key buffer handshake: two entries, encoder stalls when full
  assign key_ready_out = (q.fifo_cnt != 2'd2);
  assign push = key_valid_in && key_ready_out;
  assign push_code = key_is_pad_in ? pad_code(pad_index_in, pad_control_option_in)
                                   : key_code_in;
  assign pop = q.selected && (q.mode == RD_DATA) && strobe_edge && (q.fifo_cnt != 2'd0);

  // Combined status word; display ready shares the address
  always_comb begin
    status_word = 8'h00;
    status_word[`KB_ST_DISP_READY_BIT] = display_ready_in;
    status_word[`KB_ST_CHAR_READY_BIT] = (q.fifo_cnt != 2'd0);
    status_word[`KB_ST_KEY_SW_BIT] = q.key_sw_flag | keyboard_switch_in;
    status_word[`KB_ST_DISP_SW_BIT] = q.disp_sw_flag | display_switch_in;
  end

  // Next state of the whole unit
  always_comb begin
    d = q;
    d.cmd_prev = cmd_now;
    d.strobe_prev = input_strobe_in;
    d.key_prev = key_now;
    d.run_pulse = 1'b0;
    d.halt_pulse = 1'b0;
    d.boot_pulse = 1'b0;
    d.abort_pulse = 1'b0;

    // Device selection; any other address deselects
    if (cmd_edge[CMD_SEL]) begin
      d.selected = addr_match(bus_wdata_in, `KB_DEVICE_NUM);
      d.mode = RD_STATUS;
    end else if (q.selected && cmd_edge[CMD_DATA]) begin
      d.mode = RD_DATA;
    end else if (q.selected && cmd_edge[CMD_STAT]) begin
      d.mode = RD_STATUS;
    end

    // Control word: lamps follow bits 5 and 6 until the next word
    if (q.selected && cmd_edge[CMD_CW]) begin
      d.key_lamp = bus_wdata_in[`KB_CW_KEY_LAMP_BIT];
      d.disp_lamp = bus_wdata_in[`KB_CW_DISP_LAMP_BIT];
    end

    // Key buffer write and read
    if (push) begin
      d.fifo_mem[q.fifo_wr] = push_code;
      d.fifo_wr = ~q.fifo_wr;
    end
    if (pop) begin
      d.fifo_rd = ~q.fifo_rd;
    end
    case ({push, pop})
      2'b10: d.fifo_cnt = q.fifo_cnt + 2'd1;
      2'b01: d.fifo_cnt = q.fifo_cnt - 2'd1;
      default: d.fifo_cnt = q.fifo_cnt;
    endcase

    // Switch flags: cleared by a status read, a press in that cycle wins
    if (q.selected && (q.mode == RD_STATUS) && strobe_edge) begin
      d.key_sw_flag = 1'b0;
      d.disp_sw_flag = 1'b0;
    end
    if (keyboard_switch_in) begin
      d.key_sw_flag = 1'b1;
    end
    if (display_switch_in) begin
      d.disp_sw_flag = 1'b1;
    end

    // Read data register: status or buffered character
    if (d.mode == RD_DATA) begin
      d.rdata = {1'b0, d.fifo_mem[d.fifo_rd]};
    end else begin
      d.rdata = 8'h00;
      d.rdata[`KB_ST_DISP_READY_BIT] = display_ready_in;
      d.rdata[`KB_ST_CHAR_READY_BIT] = (d.fifo_cnt != 2'd0);
      d.rdata[`KB_ST_KEY_SW_BIT] = d.key_sw_flag | keyboard_switch_in;
      d.rdata[`KB_ST_DISP_SW_BIT] = d.disp_sw_flag | display_switch_in;
    end

    // Tone generator: square wave for a fixed length, retriggerable
    if (q.selected && cmd_edge[CMD_TONE]) begin
      d.tone_on = 1'b1;
      d.tone_level = 1'b1;
      d.tone_len = 20'h0_0000;
      d.tone_half = 12'h000;
    end else if (q.tone_on) begin
      if (q.tone_len == TONE_LEN - 20'h0_0001) begin
        d.tone_on = 1'b0;
        d.tone_level = 1'b0;
      end else begin
        d.tone_len = q.tone_len + 20'h0_0001;
        if (q.tone_half == TONE_HALF - 12'h001) begin
          d.tone_half = 12'h000;
          d.tone_level = ~q.tone_level;
        end else begin
          d.tone_half = q.tone_half + 12'h001;
        end
      end
    end

    // Click: one pulse of fixed length to the speaker driver
    if (q.selected && cmd_edge[CMD_CLICK]) begin
      d.click_len = CLICK_LEN;
    end else if (q.click_len != 16'h0000) begin
      d.click_len = q.click_len - 16'h0001;
    end

    // Run key starts at the current program counter
    if (key_edge[0]) begin
      d.run_pulse = 1'b1;
    end

    // Stop and restart keys; stop acts as restart with tab removed
    case (q.phase)
      PH_IDLE: begin
        if (key_edge[2] || (key_edge[1] && auto_restart_tab_removed_in)) begin
          d.phase = PH_WAIT_DONE;
          d.boot_pending = 1'b1;
          d.abort_pulse = 1'b1;
        end else if (key_edge[1]) begin
          d.phase = PH_WAIT_DONE;
          d.boot_pending = 1'b0;
          d.abort_pulse = 1'b1;
        end
      end
      PH_WAIT_DONE: begin
        if (instr_done_in) begin
          d.halt_pulse = 1'b1;
          d.phase = q.boot_pending ? PH_BOOT : PH_IDLE;
        end
      end
      PH_BOOT: begin
        d.boot_pulse = 1'b1;
        d.boot_pending = 1'b0;
        d.phase = PH_IDLE;
      end
      default: begin
        d.phase = PH_IDLE;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign bus_rdata_out = q.rdata;
  assign bus_rdata_oe_out = q.selected;
  assign keyboard_lamp_out = q.key_lamp;
  assign display_lamp_out = q.disp_lamp;
  assign tone_out = q.tone_level;
  assign click_out = (q.click_len != 16'h0000);
  assign run_request_out = q.run_pulse;
  assign halt_request_out = q.halt_pulse;
  assign restart_load_out = q.boot_pulse;
  assign tape_abort_out = q.abort_pulse;

endmodule
`default_nettype wire

// file: design/keyboard_io_unit_params.svh
/*
  Constants of the keyboard unit: device number, status and control word
  bit positions, key code bases and timing figures.
  Assumes a 10 MHz system clock; included by bare name.
*/
`ifndef KEYBOARD_IO_UNIT_PARAMS_SVH
`define KEYBOARD_IO_UNIT_PARAMS_SVH

// System clock rate
`define KB_CLK_HZ 10_000_000

// Four-bit device number; the address word adds its complement on top
`define KB_DEVICE_NUM 4'h1

// Status word bit positions
`define KB_ST_DISP_READY_BIT 0
`define KB_ST_CHAR_READY_BIT 1
`define KB_ST_KEY_SW_BIT 2
`define KB_ST_DISP_SW_BIT 3

// Control word bit positions
`define KB_CW_KEY_LAMP_BIT 5
`define KB_CW_DISP_LAMP_BIT 6

// Numeric pad coding
`define KB_PAD_PERIOD_IDX 4'hA
`define KB_PAD_LAST_IDX 4'hA
`define KB_PAD_DIGIT_BASE 7'h30
`define KB_PAD_PERIOD_CODE 7'h2E
`define KB_PAD_CTL_BASE 7'h10
`define KB_PAD_CTL_PERIOD_CODE 7'h0E

// Tone and click timing
`define KB_TONE_HZ 1500
`define KB_TONE_MS 100
`define KB_CLICK_US 500
`define KB_TONE_HALF_CYCLES (`KB_CLK_HZ / (2 * `KB_TONE_HZ))
`define KB_TONE_CYCLES ((`KB_CLK_HZ / 1000) * `KB_TONE_MS)
`define KB_CLICK_CYCLES ((`KB_CLK_HZ / 1_000_000) * `KB_CLICK_US)

`endif

// file: design/keyboard_io_unit_pkg.sv
/*
  Types of the keyboard unit: read mode, front panel phase and the state
  record. Assumes nothing of its surroundings.
*/
`default_nettype none
package keyboard_io_unit_pkg;

  typedef enum logic {
    RD_STATUS,
    RD_DATA
  } read_mode_e;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WAIT_DONE,
    PH_BOOT
  } panel_phase_e;

  typedef struct packed {
    logic selected;
    read_mode_e mode;
    logic [6:0] cmd_prev;
    logic strobe_prev;
    logic [2:0] key_prev;
    logic [1:0][6:0] fifo_mem;
    logic fifo_wr;
    logic fifo_rd;
    logic [1:0] fifo_cnt;
    logic key_sw_flag;
    logic disp_sw_flag;
    logic key_lamp;
    logic disp_lamp;
    logic [7:0] rdata;
    logic tone_on;
    logic tone_level;
    logic [19:0] tone_len;
    logic [11:0] tone_half;
    logic [15:0] click_len;
    panel_phase_e phase;
    logic boot_pending;
    logic run_pulse;
    logic halt_pulse;
    logic boot_pulse;
    logic abort_pulse;
  } kb_state_s;

endpackage
`default_nettype wire

// file: dv/host_bus_model.sv
/*
  Host processor side of the I/O bus: address words, command pulses, input strobe.
  Assumes the unit samples on the rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  input wire logic sys_clk_in,
  output logic [7:0] wdata_out,
  output logic [5:0] cmd_out,
  output logic strobe_out
);
  initial begin
    wdata_out = 8'h00;
    cmd_out = 6'h00;
    strobe_out = 1'b0;
  end
  // Device number low, complement high
  function automatic logic [7:0] addr_word(input logic [3:0] num);
    return {~num, num};
  endfunction
  // One command pulse of 48 cycles, word held across it
  task automatic pulse(input int idx, input logic [7:0] word);
    @(posedge sys_clk_in);
    #1;
    wdata_out = word;
    cmd_out[idx] = 1'b1;
    repeat (48) @(posedge sys_clk_in);
    #1;
    cmd_out[idx] = 1'b0;
    wdata_out = ~word;
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask
  // Input instruction strobe
  task automatic strobe;
    @(posedge sys_clk_in);
    #1;
    strobe_out = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    strobe_out = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// file: dv/keyboard_io_unit_chk.sv
/*
  Port checker of the keyboard unit.
  Bound to the unit; CLICK_CYCLES must match the unit's value.
*/
`timescale 1ns/10ps
`default_nettype none
module keyboard_io_unit_chk #(
  parameter int CLICK_CYCLES = 10
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_rdata_oe_out,
  input wire logic select_device_command_in,
  input wire logic control_word_command_in,
  input wire logic tone_command_in,
  input wire logic click_command_in,
  input wire logic keyboard_lamp_out,
  input wire logic display_lamp_out,
  input wire logic tone_out,
  input wire logic click_out,
  input wire logic instr_done_in,
  input wire logic halt_request_out
);
  logic [15:0] click_cnt_q;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // Length of the current click
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !click_out) begin
      click_cnt_q <= 16'h0000;
    end else begin
      click_cnt_q <= click_cnt_q + 16'h0001;
    end
  end
  a_select_hit: assert property (
    $rose(select_device_command_in) && bus_wdata_in == 8'hE1 |=> bus_rdata_oe_out)
    else $error("own address did not select");
  a_select_miss: assert property (
    $rose(select_device_command_in) && bus_wdata_in != 8'hE1 |=> !bus_rdata_oe_out)
    else $error("foreign address selected");
  a_lamp_update: assert property (
    $rose(control_word_command_in) && bus_rdata_oe_out
    |=> {1'b0, display_lamp_out, keyboard_lamp_out, 5'h00} == ($past(bus_wdata_in) & 8'h60))
    else $error("lamps differ from control word");
  a_lamp_hold: assert property (
    !$rose(control_word_command_in) |=> $stable({keyboard_lamp_out, display_lamp_out}))
    else $error("lamp changed without control word");
  a_tone_start: assert property (
    $rose(tone_command_in) && bus_rdata_oe_out |=> tone_out)
    else $error("tone did not start");
  a_click_start: assert property (
    $rose(click_command_in) && bus_rdata_oe_out |=> click_out [*2])
    else $error("click did not start");
  a_click_len: assert property (
    $fell(click_out) |-> click_cnt_q == 16'(CLICK_CYCLES))
    else $error("click length wrong");
  a_halt_after_done: assert property (
    halt_request_out |-> $past(instr_done_in))
    else $error("halt before instruction done");
endmodule
`default_nettype wire

// file: dv/keyboard_io_unit_tb_top.sv
/*
  Bench of the keyboard unit with the host bus model and bound checker.
  Assumes a 100 ns clock; inputs change 1 ns after the rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module keyboard_io_unit_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] wd, rd, seen;
  logic [5:0] cmd;
  logic stb, oe, kr, kl, dl, tone, click, rq, halt, load, abort;
  logic dr, kv, kp, kb, dp, run, stop, rk, tab, done;
  logic [6:0] kc = 7'h00;
  logic [3:0] pi = 4'h0;
  logic po = 1'b0;
  int error_cnt = 0;
  int total_checks = 0;
  logic [9:0] rows [4] = '{{8'h20, 2'b10}, {8'h40, 2'b01}, {8'h60, 2'b11}, {8'h9F, 2'b00}};
  always #50 clk = ~clk;
  host_bus_model host (.sys_clk_in(clk), .wdata_out(wd), .cmd_out(cmd), .strobe_out(stb));
  keyboard_io_unit #(.TONE_CYCLES(20000), .CLICK_CYCLES(10)) DUT (
    .sys_clk_in(clk), .reset_in(rst), .bus_wdata_in(wd), .bus_rdata_out(rd), .bus_rdata_oe_out(oe),
    .select_device_command_in(cmd[0]), .sense_status_command_in(cmd[1]), .sense_data_command_in(cmd[2]),
    .control_word_command_in(cmd[3]), .tone_command_in(cmd[4]), .click_command_in(cmd[5]),
    .input_strobe_in(stb), .display_ready_in(dr), .key_valid_in(kv), .key_is_pad_in(kp),
    .key_code_in(kc), .pad_index_in(pi), .pad_control_option_in(po), .key_ready_out(kr),
    .keyboard_switch_in(kb), .display_switch_in(dp), .keyboard_lamp_out(kl), .display_lamp_out(dl),
    .tone_out(tone), .click_out(click), .run_key_in(run), .stop_key_in(stop), .restart_key_in(rk),
    .auto_restart_tab_removed_in(tab), .instr_done_in(done), .run_request_out(rq),
    .halt_request_out(halt), .restart_load_out(load), .tape_abort_out(abort)
  );
  // Comparison and verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Key encoder handshake
  task automatic key(input logic pad, input logic [6:0] code, input logic [3:0] idx);
    tick(1);
    {kv, kp, kc, pi} = {1'b1, pad, code, idx};
    for (int i = 0; i < 20 && kr !== 1'b1; i++) tick(1);
    tick(1);
    kv = 1'b0;
  endtask
  // Front panel key; seen holds pulses before and after instruction done
  task automatic panel(input logic [2:0] keys, input logic t);
    {run, stop, rk} = keys;
    tab = t;
    seen = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i == 4) done = 1'b1;
      tick(1);
      if (i < 4) seen[7:4] = seen[7:4] | {rq, abort, halt, load};
      else seen[3:0] = seen[3:0] | {rq, abort, halt, load};
    end
    {run, stop, rk, done, tab} = 5'h00;
    tick(2);
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end
  // Main sequence
  initial begin
    {dr, kv, kp, kb, dp, run, stop, rk, tab, done} = 10'h200;
    tick(6);
    rst = 1'b0;
    check({oe, kl, dl, tone, click, halt, load, abort}, 8'h00);
    host.pulse(4, 8'h00);
    check({7'h00, tone}, 8'h00);
    host.pulse(0, 8'hE2);
    check({7'h00, oe}, 8'h00);
    host.pulse(0, 8'hF1);
    check({7'h00, oe}, 8'h00);
    host.pulse(0, host.addr_word(4'h1));
    check({7'h00, oe}, 8'h01);
    check(rd, 8'h01);
    foreach (rows[i]) begin
      host.pulse(3, rows[i][9:2]);
      check({6'h00, kl, dl}, {6'h00, rows[i][1:0]});
    end
    // Sticky switch flags, cleared by a status read
    kb = 1'b1;
    tick(2);
    kb = 1'b0;
    tick(2);
    check(rd, 8'h05);
    dp = 1'b1;
    tick(2);
    dp = 1'b0;
    kb = 1'b1;
    tick(2);
    check(rd, 8'h0D);
    kb = 1'b0;
    host.strobe;
    check(rd, 8'h01);
    // Two keys fill the buffer, a third waits
    key(1'b0, 7'h41, 4'h0);
    key(1'b1, 7'h00, 4'h3);
    check({7'h00, kr}, 8'h00);
    check(rd, 8'h03);
    {kv, kp, kc} = {1'b1, 1'b0, 7'h7F};
    host.pulse(2, 8'h00);
    check(rd, 8'h41);
    host.strobe;
    kv = 1'b0;
    check(rd, 8'h33);
    host.strobe;
    check(rd, 8'h7F);
    host.strobe;
    host.pulse(1, 8'h00);
    check(rd, 8'h01);
    po = 1'b1;
    key(1'b1, 7'h00, 4'hA);
    host.pulse(2, 8'h00);
    check(rd, 8'h0E);
    host.strobe;
    // Tone halves of 3333 cycles, then silence
    host.pulse(4, 8'h00);
    check({7'h00, tone}, 8'h01);
    tick(3300);
    check({7'h00, tone}, 8'h00);
    tick(3400);
    check({7'h00, tone}, 8'h01);
    tick(14000);
    check({7'h00, tone}, 8'h00);
    host.pulse(5, 8'h00);
    check({7'h00, click}, 8'h00);
    panel(3'b100, 1'b0);
    check(seen, 8'h80);
    panel(3'b010, 1'b0);
    check(seen, 8'h42);
    panel(3'b001, 1'b0);
    check(seen, 8'h43);
    panel(3'b010, 1'b1);
    check(seen, 8'h43);
    print_verdict;
  end
endmodule
bind keyboard_io_unit keyboard_io_unit_chk #(.CLICK_CYCLES(CLICK_CYCLES)) chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .bus_wdata_in(bus_wdata_in),
  .bus_rdata_oe_out(bus_rdata_oe_out), .select_device_command_in(select_device_command_in),
  .control_word_command_in(control_word_command_in), .tone_command_in(tone_command_in),
  .click_command_in(click_command_in), .keyboard_lamp_out(keyboard_lamp_out),
  .display_lamp_out(display_lamp_out), .tone_out(tone_out), .click_out(click_out),
  .instr_done_in(instr_done_in), .halt_request_out(halt_request_out)
);
`default_nettype wire
